// file: tb/ffh_convert_sva.sv
// Checker for the conversion datapath, bound to its top module.
// Assumes ce stays high while instructions are offered.
`timescale 1ns/1ns
`include "ffh_map.svh"
module ffh_convert_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Instruction side.
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   input wire logic cond_pass,
   input wire logic [4:0] rd_index,
   // Results.
   input wire ffh_pkg::ffh_wb_t wb,
   input wire ffh_pkg::ffh_flags_t exc_flags,
   input wire logic exc_valid,
   input wire logic undef_fault
);
   logic go;
   logic fix;
   logic half;
   logic [4:0] dest;
   // Decode once here, so each property states only its own relation.
   assign go = ce && instr_valid && cond_pass;
   assign fix = ((instr[31:16] & `FFH_FIX_HW1_MASK) == `FFH_FIX_HW1_VAL) &&
      ((instr[15:0] & `FFH_HW2_MASK) == `FFH_HW2_VAL);
   assign half = ((instr[31:16] & `FFH_HALF_HW1_MASK) == `FFH_HALF_HW1_VAL) &&
      ((instr[15:0] & `FFH_HW2_MASK) == `FFH_HW2_VAL);
   assign dest = {instr[15:12], instr[22]};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_quiet_refused: assert property (
      ce && instr_valid && !cond_pass |=> !wb.valid && !undef_fault)
      else $error("refused instruction gave an answer");
   a_fault_no_write: assert property (undef_fault |-> !wb.valid)
      else $error("fault came with a write");
   a_one_answer: assert property (go |=> wb.valid ^ undef_fault)
      else $error("accepted instruction did not give exactly one answer");
   a_flag_pulse: assert property (exc_valid == (wb.valid && (|exc_flags)))
      else $error("exception pulse does not match flags");
   a_flags_with_result: assert property ((|exc_flags) |-> wb.valid)
      else $error("flags without a result");
   a_fixed_one_reg: assert property (
      go && fix |-> rd_index == dest ##1 (!wb.valid || wb.index == $past(dest)))
      else $error("fixed conversion register index wrong");
   a_half_src_index: assert property (
      go && half |-> rd_index == {instr[3:0], instr[5]})
      else $error("half conversion source index wrong");
   a_half_lane: assert property (
      go && half && instr[16] |=> !wb.valid || wb.half_en == ($past(instr[7]) ? 2'h2 : 2'h1))
      else $error("narrow write lane wrong");
   a_half_full: assert property (
      go && half && !instr[16] |=> !wb.valid || (wb.half_en == 2'h3 && wb.index == $past(dest)))
      else $error("widening write not full word");
   a_sign_fill: assert property (
      go && fix && instr[18] && !instr[16] && !instr[7]
      |=> !wb.valid || wb.data[31:16] == {16{wb.data[15]}})
      else $error("signed result not sign-extended");
   a_zero_fill: assert property (
      go && fix && instr[18] && instr[16] && !instr[7] |=> !wb.valid || wb.data[31:16] == 16'h0)
      else $error("unsigned result not zero-extended");
   a_neg_fraction: assert property (
      go && fix && !instr[7] && {instr[3:0], instr[5]} > 5'h10 |=> undef_fault)
      else $error("negative fraction count accepted");
   a_fixed_flags: assert property (
      go && fix |=> !exc_flags.ufc && !exc_flags.ofc)
      else $error("fixed conversion raised a foreign flag");
   c_half: cover property (go && half ##1 wb.valid);
   c_fix_exc: cover property (go && fix ##1 exc_valid);
   c_fault: cover property (undef_fault);
endmodule // ffh_convert_chk
bind ffh_convert ffh_convert_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
   .instr_valid(instr_valid), .instr(instr), .cond_pass(cond_pass), .rd_index(rd_index),
   .wb(wb), .exc_flags(exc_flags), .exc_valid(exc_valid), .undef_fault(undef_fault));

// file: tb/ffh_regfile_model.sv
// Extension register file facing the conversion unit: 32 words.
// Assumes the bench preloads words by hierarchical access between edges.
`timescale 1ns/1ns
module ffh_regfile_model (
   // Clock.
   input wire logic clk,
   // Read port.
   input wire logic [4:0] rd_index,
   output logic [31:0] rd_data,
   // Write port.
   input wire ffh_pkg::ffh_wb_t wb
);
   logic [31:0] mem [32];
   // Reads are combinational, as the unit samples them in the same cycle.
   assign rd_data = mem[rd_index];
   // Lanes are written apart, so a narrow write keeps its neighbour half.
   always @(posedge clk) begin
      if (wb.valid === 1'b1) begin
         if (wb.half_en[1]) mem[wb.index][31:16] <= wb.data[31:16];
         if (wb.half_en[0]) mem[wb.index][15:0] <= wb.data[15:0];
      end
   end
endmodule // ffh_regfile_model

// file: tb/tb_fp_fixed_half_convert.sv
// Self-checking bench for the conversion datapath with a register file model.
// Assumes the package, design, checker and model are compiled before it.
`timescale 1ns/1ns
`include "ffh_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_fp_fixed_half_convert;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   logic [31:0] instr = 32'h0;
   logic cond_pass = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] rd_index;
   logic [31:0] rd_data;
   logic [31:0] prdata;
   logic [31:0] rv;
   logic pready, pslverr, exc_valid, undef_fault, err;
   ffh_pkg::ffh_wb_t wb;
   ffh_pkg::ffh_flags_t exc_flags;
   ffh_pkg::ffh_flags_t cap_fl;
   int miscompares = 0;
   int check_count = 0;
   int nwr = 0;
   ffh_convert DUT (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
      .cond_pass(cond_pass), .rd_index(rd_index), .rd_data(rd_data), .wb(wb),
      .exc_flags(exc_flags), .exc_valid(exc_valid), .undef_fault(undef_fault), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ffh_regfile_model u_rf (.clk(clk), .rd_index(rd_index), .rd_data(rd_data), .wb(wb));
   // Free-running clock at 25 MHz.
   always #20 clk = ~clk;
   // Ends the run with the verdict.
   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One APB transfer; the wait is bounded so a dead slave cannot hang the run.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // One instruction; the answer stands in the cycle after it is taken.
   task automatic exec(input logic [31:0] ins, input logic cp, input logic w);
      @(posedge clk);
      instr <= ins;
      cond_pass <= cp;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      cap_fl = exc_flags;
      `CHK(wb.valid, w)
      `CHK(undef_fault, cp & !w)
      nwr += int'(w);
      @(posedge clk);
      #1;
   endtask
   // Fixed conversion encoding: the field holds width minus fraction bits.
   function automatic logic [31:0] enc_fix(logic op, logic u, logic sx, int fb, logic [4:0] r);
      logic [4:0] f;
      f = 5'((sx ? 32 : 16) - fb);
      return {`FFH_FIX_HW1_VAL | {9'h0, r[0], 3'h0, op, 1'b0, u},
         `FFH_HW2_VAL | {r[4:1], 4'h0, sx, 1'b0, f[0], 1'b0, f[4:1]}};
   endfunction
   // Half conversion encoding with destination d and source m.
   function automatic logic [31:0] enc_half(logic op, logic t, logic [4:0] d, logic [4:0] m);
      return {`FFH_HALF_HW1_VAL | {9'h0, d[0], 5'h0, op},
         `FFH_HW2_VAL | {d[4:1], 4'h0, t, 1'b0, m[0], 1'b0, m[4:1]}};
   endfunction
   // Fixed operand to single precision, rounding to nearest even.
   function automatic logic [31:0] fx2f(logic [31:0] v, logic sx, logic u, int fb);
      logic s;
      logic [31:0] m;
      logic [32:0] k;
      int p;
      int sh;
      if (!sx) v = u ? {16'h0, v[15:0]} : {{16{v[15]}}, v[15:0]};
      s = !u && v[31];
      m = s ? -v : v;
      if (m == 0) return 32'h0;
      p = 31;
      while (!m[p]) p--;
      sh = p - 23;
      k = (sh <= 0) ? {1'b0, m} << -sh : m >> sh;
      if (sh > 0 && m[sh-1] && ((m & ((32'h1 << (sh - 1)) - 1)) != 0 || k[0])) k++;
      if (k[24]) begin
         k = k >> 1;
         p++;
      end
      return {s, 8'(127 + p - fb), k[22:0]};
   endfunction
   // Main sequence: corner cases first, then random traffic.
   initial begin
      logic [31:0] r, k;
      logic [15:0] h;
      logic op, u, sx, t;
      int fb;
      logic [4:0] a, b;
      void'($urandom(3));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      u_rf.mem[1] = 32'h3FE0_0000;
      exec(enc_fix(1, 0, 0, 0, 1), 1, 0);
      apb(1, `FFH_CTRL_OFFSET, 32'h1);
      apb(0, 12'h00C, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rv, 32'h0)
      exec(enc_fix(1, 0, 0, 0, 1), 0, 0);
      exec(enc_fix(1, 0, 0, 0, 1), 1, 1);
      `CHK(u_rf.mem[1], 32'h1)
      `CHK(cap_fl, 5'h08)
      u_rf.mem[2] = 32'hBFE0_0000;
      exec(enc_fix(1, 0, 0, 0, 2), 1, 1);
      `CHK(u_rf.mem[2], 32'hFFFF_FFFF)
      u_rf.mem[3] = 32'h477F_FF00;
      exec(enc_fix(1, 1, 0, 0, 3), 1, 1);
      `CHK(u_rf.mem[3], 32'h0000_FFFF)
      u_rf.mem[4] = 32'h7FC0_0000;
      exec(enc_fix(1, 0, 1, 1, 4), 1, 1);
      `CHK(cap_fl, 5'h01)
      u_rf.mem[5] = 32'h0200_0003;
      exec(enc_fix(0, 0, 1, 1, 5), 1, 1);
      `CHK(u_rf.mem[5], 32'h4B80_0001)
      exec(enc_fix(1, 0, 0, -4, 6), 1, 0);
      apb(1, `FFH_CTRL_OFFSET, 32'h3);
      u_rf.mem[7] = 32'h1;
      exec(enc_fix(1, 0, 1, 1, 7), 1, 1);
      `CHK(cap_fl, 5'h10)
      apb(1, `FFH_CTRL_OFFSET, 32'h1);
      apb(0, `FFH_CTRL_OFFSET, 32'h0);
      `CHK(rv, 32'h1)
      apb(0, `FFH_STATUS_OFFSET, 32'h0);
      `CHK(rv, 32'h19)
      apb(1, `FFH_STATUS_OFFSET, 32'h1F);
      apb(0, `FFH_STATUS_OFFSET, 32'h0);
      `CHK(rv, 32'h0)
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         {op, u, sx, a} = r[31:24];
         fb = sx ? 1 + $urandom % 32 : $urandom % 17;
         k = sx ? (u ? {8'h0, r[23:0]} : {{8{r[23]}}, r[23:0]})
            : (u ? {16'h0, r[15:0]} : {{16{r[15]}}, r[15:0]});
         u_rf.mem[a] = op ? fx2f(k, sx, u, fb) : r;
         if (!op) k = fx2f(r, sx, u, fb);
         exec(enc_fix(op, u, sx, fb, a), 1, 1);
         `CHK(u_rf.mem[a], k)
      end
      for (int i = 0; i < 40; i++) begin
         r = $urandom;
         h = {r[15], 5'(1 + r[20:16] % 30), r[9:0]};
         {op, t, a} = r[31:25];
         b = a ^ 5'(1 + r[24:21]);
         k = $urandom;
         u_rf.mem[a] = k;
         r = {h[15], 8'(h[14:10] + 112), h[9:0], 13'h0};
         u_rf.mem[b] = op ? r : (t ? {h, k[15:0]} : {k[31:16], h});
         exec(enc_half(op, t, a, b), 1, 1);
         if (op) `CHK(u_rf.mem[a], t ? {h, k[15:0]} : {k[31:16], h})
         else `CHK(u_rf.mem[a], r)
      end
      apb(0, `FFH_COUNT_OFFSET, 32'h0);
      `CHK(rv, 32'(nwr))
      print_verdict();
   end
endmodule // tb_fp_fixed_half_convert

// file: verilog/ffh_convert.sv
// Conversion datapath: single to and from fixed point, half to and from single.
// Assumes the decoder gives one instruction a cycle and the register file reads
// combinationally within that cycle; registers sit behind an APB slave.
`timescale 1ns/1ns
`include "ffh_map.svh"
module ffh_convert #(
   parameter int COUNT_WIDTH = 16
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Instruction from the decoder.
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   input wire logic cond_pass,
   // Register file read port.
   output logic [4:0] rd_index,
   input wire logic [31:0] rd_data,
   // Register file write port and exception indications.
   output ffh_pkg::ffh_wb_t wb,
   output ffh_pkg::ffh_flags_t exc_flags,
   output logic exc_valid,
   output logic undef_fault,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Refuse at elaboration a count that the 32-bit read word cannot carry.
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 32) begin : g_bad_count
      $error("COUNT_WIDTH must lie between 1 and 32");
   end

   // Register index from a 4-bit field and its extra low bit.
   function automatic logic [4:0] reg_index(input logic [3:0] field, input logic low);
      reg_index = {field, low};
   endfunction

   logic [15:0] hw1;
   logic [15:0] hw2;
   logic is_fixed;
   logic is_half;
   logic [4:0] d_idx;
   logic [4:0] m_idx;
   logic wide;
   logic uns;
   logic top;
   logic [5:0] size;
   logic [6:0] frac;
   logic frac_neg;
   logic [5:0] fbits;
   ffh_pkg::ffh_op_t op;
   logic [1:0] ctrl;
   ffh_pkg::ffh_flags_t sticky_flags;
   logic [COUNT_WIDTH-1:0] done_count;
   logic take;
   logic fault;

   // Instruction decode.
   always_comb begin
      hw1 = instr[31:16];
      hw2 = instr[15:0];
      is_fixed = ((hw1 & `FFH_FIX_HW1_MASK) == `FFH_FIX_HW1_VAL)
         && ((hw2 & `FFH_HW2_MASK) == `FFH_HW2_VAL);
      is_half = ((hw1 & `FFH_HALF_HW1_MASK) == `FFH_HALF_HW1_VAL)
         && ((hw2 & `FFH_HW2_MASK) == `FFH_HW2_VAL);
      d_idx = reg_index(hw2[15:12], hw1[`FFH_HW1_DBIT]);
      m_idx = reg_index(hw2[3:0], hw2[`FFH_HW2_LOWBIT]);
      wide = hw2[`FFH_HW2_WSEL];
      uns = hw1[`FFH_HW1_UNS];
      top = hw2[`FFH_HW2_WSEL];
      size = wide ? 6'd32 : 6'd16;
      // The producer encodes width minus count; anything else goes negative.
      frac = {1'b0, size} - {2'b00, hw2[3:0], hw2[`FFH_HW2_LOWBIT]};
      frac_neg = frac[6];
      fbits = frac[5:0];
      if (is_fixed) begin
         op = hw1[`FFH_HW1_DIR] ? ffh_pkg::FFH_OP_TO_FIXED : ffh_pkg::FFH_OP_FROM_FIXED;
      end else if (is_half) begin
         op = hw1[`FFH_HW1_HDIR] ? ffh_pkg::FFH_OP_SGL_TO_HALF
            : ffh_pkg::FFH_OP_HALF_TO_SGL;
      end else begin
         op = ffh_pkg::FFH_OP_NONE;
      end
      // The fixed form uses one register as source and destination.
      rd_index = is_fixed ? d_idx : m_idx;
      take = instr_valid && cond_pass;
      // Negative counts fault rather than write anything.
      fault = !ctrl[`FFH_CTRL_ENABLE] || op == ffh_pkg::FFH_OP_NONE
         || (is_fixed && frac_neg);
   end

   // Single to fixed point.
   logic fs;
   logic [7:0] fe;
   logic [23:0] fman;
   logic [9:0] fsh;
   logic [5:0] frs;
   logic [64:0] fext;
   logic [40:0] fmag;
   logic flost;
   logic fbig;
   logic [41:0] flim;
   logic fovf;
   logic fnan;
   logic fzero;
   logic [31:0] fraw;
   logic [31:0] fixed_res;
   ffh_pkg::ffh_flags_t fixed_fl;

   always_comb begin
      fs = rd_data[31];
      fe = rd_data[30:23];
      fnan = fe == 8'hFF && rd_data[22:0] != 23'h000000;
      fzero = fe == 8'h00 && (rd_data[22:0] == 23'h000000 || ctrl[`FFH_CTRL_FTZ]);
      fman = fzero ? 24'h000000 : {fe != 8'h00, rd_data[22:0]};
      fsh = 10'({2'b00, (fe == 8'h00) ? 8'h01 : fe}) - 10'd150 + {4'b0000, fbits};
      fbig = fe == 8'hFF;
      fmag = '0;
      flost = 1'b0;
      frs = 6'd0;
      fext = '0;
      if (!fsh[9]) begin
         fbig = fbig || (fsh > 10'd17 && !fzero);
         fmag = {17'h00000, fman} << fsh[4:0];
      end else begin
         // Round towards zero: bits shifted out are dropped, only noted.
         frs = (10'(-fsh) > 10'd41) ? 6'd41 : 6'(10'(-fsh));
         fext = {fman, 41'h0} >> frs;
         fmag = {17'h00000, fext[64:41]};
         flost = |fext[40:0];
      end
      if (uns) begin
         flim = fs ? 42'h0 : 42'((64'h1 << size) - 64'h1);
      end else begin
         flim = 42'((64'h1 << (size - 6'd1)) - {63'h0, !fs});
      end
      fovf = fbig || {1'b0, fmag} > flim;
      fraw = fs ? 32'(-fmag[31:0]) : fmag[31:0];
      if (fnan) begin
         fraw = 32'h00000000;
      end else if (fovf) begin
         fraw = fs ? 32'(-flim[31:0]) : flim[31:0];
      end
      // Extend the selected width to the full register.
      if (!wide) begin
         fixed_res = uns ? {16'h0000, fraw[15:0]}
            : {{16{fraw[15]}}, fraw[15:0]};
      end else begin
         fixed_res = fraw;
      end
      fixed_fl.ioc = fnan || fovf;
      fixed_fl.ofc = 1'b0;
      fixed_fl.ufc = 1'b0;
      fixed_fl.ixc = flost && !fnan && !fovf;
      fixed_fl.idc = fe == 8'h00 && rd_data[22:0] != 23'h000000 && ctrl[`FFH_CTRL_FTZ];
   end

   // Fixed point to single; only the low width bits take part.
   logic [31:0] xval;
   logic xsign;
   logic [31:0] xmag;
   logic [31:0] flt_res;
   logic flt_inexact;

   always_comb begin
      xval = wide ? rd_data : (uns ? {16'h0000, rd_data[15:0]}
         : {{16{rd_data[15]}}, rd_data[15:0]});
      xsign = !uns && xval[31];
      xmag = xsign ? 32'(-xval) : xval;
   end

   ffh_int_to_single #(
      .MAG_WIDTH(32)
   ) u_to_single (
      .sign(xsign),
      .mag(xmag),
      .fbits(fbits),
      .result(flt_res),
      .inexact(flt_inexact)
   );

   // Half to single and single to half.
   logic [15:0] hin;
   logic [31:0] h2s_res;
   logic [3:0] hp;
   logic [9:0] hm;
   logic hsnan;
   logic [23:0] sman;
   logic [8:0] he;
   logic hnorm;
   logic [5:0] hsh;
   logic [49:0] hext;
   logic hg;
   logic hst;
   logic [14:0] hsum;
   logic [15:0] s2h_res;
   ffh_pkg::ffh_flags_t half_fl;

   always_comb begin
      hin = top ? rd_data[31:16] : rd_data[15:0];
      hp = 4'd0;
      for (int k = 0; k < 10; k++) begin
         if (hin[k]) begin
            hp = 4'(k);
         end
      end
      hm = 10'(hin[9:0] << (4'd10 - hp));
      half_fl = '0;
      hsnan = hin[14:10] == 5'h1F && hin[9:0] != 10'h000 && !hin[9];
      if (hin[14:10] == 5'h1F) begin
         h2s_res = {hin[15], 8'hFF, hin[9:0] != 10'h000, hin[8:0], 13'h0000};
      end else if (hin[14:10] == 5'h00) begin
         h2s_res = (hin[9:0] == 10'h000) ? {hin[15], 31'h0}
            : {hin[15], 8'(8'd103 + {4'h0, hp}), hm, 13'h0000};
      end else begin
         h2s_res = {hin[15], 8'(8'd112 + {3'b000, hin[14:10]}), hin[9:0], 13'h0000};
      end
      // Single to half rounds to nearest even; tininess is judged before rounding.
      sman = {rd_data[30:23] != 8'h00, rd_data[22:0]};
      he = 9'({1'b0, rd_data[30:23]}) - 9'd112;
      hnorm = !he[8] && he != 9'd0;
      hsh = hnorm ? 6'd13 : ((9'd126 - {1'b0, rd_data[30:23]} > 9'd40) ? 6'd40
         : 6'(9'd126 - {1'b0, rd_data[30:23]}));
      hext = {sman, 26'h0} >> hsh;
      hg = hext[25];
      hst = |hext[24:0];
      hsum = (hnorm ? {he[4:0], hext[35:26]} : {5'h00, hext[35:26]})
         + {14'h0000, hg & (hst | hext[26])};
      if (op == ffh_pkg::FFH_OP_HALF_TO_SGL) begin
         half_fl.ioc = hsnan;
      end
      if (rd_data[30:23] == 8'hFF) begin
         s2h_res = {rd_data[31], 5'h1F, rd_data[22:0] != 23'h0, rd_data[21:13]};
         if (op == ffh_pkg::FFH_OP_SGL_TO_HALF) begin
            half_fl.ioc = rd_data[22:0] != 23'h0 && !rd_data[22];
         end
      end else if (rd_data[30:23] == 8'h00 && ctrl[`FFH_CTRL_FTZ]) begin
         s2h_res = {rd_data[31], 15'h0000};
         half_fl.idc = rd_data[22:0] != 23'h0 && op == ffh_pkg::FFH_OP_SGL_TO_HALF;
      end else if ((!he[8] && he >= 9'd31) || hsum[14:10] == 5'h1F) begin
         s2h_res = {rd_data[31], 5'h1F, 10'h000};
         half_fl.ofc = op == ffh_pkg::FFH_OP_SGL_TO_HALF;
         half_fl.ixc = op == ffh_pkg::FFH_OP_SGL_TO_HALF;
      end else begin
         s2h_res = {rd_data[31], hsum};
         half_fl.ixc = (hg | hst) && op == ffh_pkg::FFH_OP_SGL_TO_HALF;
         half_fl.ufc = (hg | hst) && !hnorm && op == ffh_pkg::FFH_OP_SGL_TO_HALF;
      end
   end

   // Result selection for the write-back stage.
   ffh_pkg::ffh_wb_t next_wb;
   ffh_pkg::ffh_flags_t next_fl;

   always_comb begin
      next_wb = '0;
      next_fl = '0;
      next_wb.valid = take && !fault;
      case (op)
         ffh_pkg::FFH_OP_TO_FIXED: begin
            next_wb.index = d_idx;
            next_wb.half_en = 2'b11;
            next_wb.data = fixed_res;
            next_fl = fixed_fl;
         end
         ffh_pkg::FFH_OP_FROM_FIXED: begin
            next_wb.index = d_idx;
            next_wb.half_en = 2'b11;
            next_wb.data = flt_res;
            next_fl.ixc = flt_inexact;
         end
         ffh_pkg::FFH_OP_HALF_TO_SGL: begin
            next_wb.index = d_idx;
            next_wb.half_en = 2'b11;
            next_wb.data = h2s_res;
            next_fl = half_fl;
         end
         ffh_pkg::FFH_OP_SGL_TO_HALF: begin
            next_wb.index = d_idx;
            next_wb.half_en = top ? 2'b10 : 2'b01;
            next_wb.data = top ? {s2h_res, 16'h0000} : {16'h0000, s2h_res};
            next_fl = half_fl;
         end
         default: begin
            next_wb.half_en = 2'b00;
         end
      endcase
      if (!next_wb.valid) begin
         next_wb = '0;
         next_fl = '0;
      end
   end

   // Write-back stage: data, flags and fault leave together, one per instruction.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb <= '0;
         exc_flags <= '0;
         exc_valid <= 1'b0;
         undef_fault <= 1'b0;
      end else if (ce) begin
         wb <= next_wb;
         exc_flags <= next_fl;
         exc_valid <= next_wb.valid && (next_fl != '0);
         undef_fault <= take && fault;
      end
   end

   // APB decode; the slave answers with no wait states while ce is high.
   logic setup;
   logic access_wr;
   logic hit;

   always_comb begin
      setup = psel && !penable;
      access_wr = psel && penable && pwrite;
      hit = paddr == `FFH_CTRL_OFFSET || paddr == `FFH_STATUS_OFFSET
         || paddr == `FFH_COUNT_OFFSET;
      pready = ce;
      pslverr = psel && penable && !hit;
   end

   // Control register steers enable check and flush to zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= `FFH_CTRL_RESET;
      end else if (ce && access_wr && paddr == `FFH_CTRL_OFFSET) begin
         ctrl <= pwdata[1:0];
      end
   end

   // Sticky flags clear by writing one; a new event in the same cycle wins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sticky_flags <= `FFH_FLAGS_RESET;
      end else if (ce) begin
         sticky_flags <= (sticky_flags
            & ~((access_wr && paddr == `FFH_STATUS_OFFSET) ? pwdata[4:0] : 5'h00))
            | next_fl;
      end
   end

   // Count of completed writes, wrapping.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_count <= '0;
      end else if (ce && next_wb.valid) begin
         done_count <= done_count + 1'b1;
      end
   end

   // Read data is captured in the setup cycle so it stands through the access.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (ce && setup) begin
         case (paddr)
            `FFH_CTRL_OFFSET: prdata <= {30'h0, ctrl};
            `FFH_STATUS_OFFSET: prdata <= {27'h0, sticky_flags};
            `FFH_COUNT_OFFSET: prdata <= 32'(done_count);
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // ffh_convert

// file: verilog/ffh_int_to_single.sv
// Fixed-point magnitude to single precision with round to nearest even.
// Assumes a magnitude and sign prepared by the caller; purely combinational.
`timescale 1ns/1ns
module ffh_int_to_single #(
   parameter int MAG_WIDTH = 32
) (
   // Operand.
   input wire logic sign,
   input wire logic [MAG_WIDTH-1:0] mag,
   input wire logic [5:0] fbits,
   // Result.
   output logic [31:0] result,
   output logic inexact
);

   // Refuse at elaboration any magnitude width the normaliser was not built for.
   if (MAG_WIDTH != 32) begin : g_bad_width
      $error("ffh_int_to_single serves a 32-bit magnitude only");
   end

   logic [5:0] lz;
   logic [31:0] norm;
   logic guard;
   logic sticky;
   logic rnd;
   logic [7:0] expo;

   // Leading-zero count; the last hit from the bottom is the highest one.
   always_comb begin
      lz = 6'd0;
      for (int k = 0; k < 32; k++) begin
         if (mag[k]) begin
            lz = 6'(31 - k);
         end
      end
   end

   // Exponent never leaves the normal range: 1 with 32 fraction bits still gives 95.
   always_comb begin
      norm = mag << lz;
      guard = norm[7];
      sticky = |norm[6:0];
      rnd = guard & (sticky | norm[8]);
      expo = 8'(8'd158 - {2'b00, lz} - {2'b00, fbits});
      inexact = guard | sticky;
      // A carry out of the mantissa walks into the exponent by itself.
      if (mag == '0) begin
         result = 32'h00000000;
      end else begin
         result = {sign, expo, norm[30:8]} + {31'h00000000, rnd};
      end
   end

endmodule // ffh_int_to_single

// file: verilog/ffh_map.svh
// Constants for the conversion datapath: encodings, register offsets, fields, resets.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef FFH_MAP_SVH
`define FFH_MAP_SVH

// Instruction patterns, first halfword in bits 31:16.
`define FFH_FIX_HW1_MASK 16'hFFBA
`define FFH_FIX_HW1_VAL 16'hEEBA
`define FFH_HALF_HW1_MASK 16'hFFBE
`define FFH_HALF_HW1_VAL 16'hEEB2
`define FFH_HW2_MASK 16'h0F50
`define FFH_HW2_VAL 16'h0A40

// Field positions inside the two halfwords.
`define FFH_HW1_DBIT 6
`define FFH_HW1_DIR 2
`define FFH_HW1_UNS 0
`define FFH_HW1_HDIR 0
`define FFH_HW2_WSEL 7
`define FFH_HW2_LOWBIT 5

// Register offsets on the bus.
`define FFH_CTRL_OFFSET 12'h000
`define FFH_STATUS_OFFSET 12'h004
`define FFH_COUNT_OFFSET 12'h008

// Control fields and resets.
`define FFH_CTRL_ENABLE 0
`define FFH_CTRL_FTZ 1
`define FFH_CTRL_RESET 2'h0
`define FFH_FLAGS_RESET 5'h00

`endif

// file: verilog/ffh_pkg.sv
// Types shared by the conversion datapath modules.
// Assumes the constants header sits beside it.
`include "ffh_map.svh"
package ffh_pkg;

   // Floating-point exception indications, one bit each.
   typedef struct packed {
      logic idc;
      logic ixc;
      logic ufc;
      logic ofc;
      logic ioc;
   } ffh_flags_t;

   // Write-back to the extension register file.
   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic [1:0] half_en;
      logic [31:0] data;
   } ffh_wb_t;

   // Operation selected by decode.
   typedef enum logic [4:0] {
      FFH_OP_NONE = 5'b00001,
      FFH_OP_TO_FIXED = 5'b00010,
      FFH_OP_FROM_FIXED = 5'b00100,
      FFH_OP_HALF_TO_SGL = 5'b01000,
      FFH_OP_SGL_TO_HALF = 5'b10000
   } ffh_op_t;

endpackage
